// >>> hdl/sad_decoder.sv
/*
  System address decoder: one registered decode per valid address,
  giving a one-hot target select and a secure attribute.
  Assumes the address arrives from logic on ref_clk (no synchroniser)
  and that downstream slaves sample selects alongside selValid.
*/
`timescale 1ns/1ps

// Function
// [RL1] address space alternates 256MB non-secure and secure windows
// [RL2] debug areas decode identically regardless of security
// [RL3] masters must not access reserved locations; response undefined
// [RL4] software keeps undefined bits and ignores them on read
// [RL5] all state clears to zero on reset
// [RL6] four 512KB code SRAM banks at 0x0000_0000 and 0x1000_0000
// [RL7] 8MB boot flash window, only lowest 256KB directly reachable
// [RL8] OTP block 256 bytes at 0x0E00_0000 and 0x1E00_0000
// [RL9] four 32KB internal SRAM banks at 0x2000_0000 and 0x3000_0000
// [RL10] timer0, timer1, dual timer 4KB slots, secure alias +256MB
// [RL11] two message unit slots at 0x4000_3000 and 0x4000_4000
// [RL12] 64KB private core region at 0x4001_0000 and 0x5001_0000
// [RL13] system info both views; system control secure only
// [RL14] secure-only watchdog 0x5002_E000; extra timer 0x4002_F000
// [RL15] distinct privilege control blocks at 0x4008_0000, 0x5008_0000
// [RL16] watchdog at 0x4008_1000 and 0x5008_1000
// [RL17] four secure-only protection controllers from 0x5008_3000
// [RL18] six serial peripheral slots from 0x4010_1000
// [RL19] PWM0, RTC, flash control, timer, serial config selects
// [RL20] PWM1, PWM2, GPIO, flash and code SRAM protection selects
// [RL21] 0x6xxx_xxxx to default slave, 0x7xxx_xxxx to expansion port
// [RL22] unmatched address raises default select; selects one-hot
// [RL23] secure attribute comes from address bit 28
module sad_decoder
  import sad_pkg::*;
#(
  parameter int TGT_W = NUM_TGT
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic addrValid,
  input wire logic [ADDR_W-1:0] addr,
  output logic selValid,
  output logic [TGT_W-1:0] sel,
  output logic selSecure,
  output logic flashDirect,
  output logic [ADDR_W-1:0] selAddr
);

  // ==========================================================
  // helpers
  // ==========================================================
  function automatic logic inRange(input logic [31:0] a,
                                   input logic [31:0] base,
                                   input logic [31:0] size);
    inRange = (a >= base) && ((a - base) < size);
  endfunction

  // fold secure window onto non-secure view
  function automatic logic [31:0] foldNs(input logic [31:0] a);
    logic [31:0] f;
    f = a;
    f[SEC_BIT] = 1'b0;
    foldNs = f;
  endfunction

  // ==========================================================
  // combinational decode
  // ==========================================================
  logic [TGT_W-1:0] hit;
  logic hitSecure;
  logic hitFlashDirect;
  logic [31:0] nsAddr;
  logic secView;
  logic isDebug;

  always_comb begin
    hit = '0;
    nsAddr = foldNs(addr);
    isDebug = (addr >= DBG_BASE); // see [RL2]
    secView = addr[SEC_BIT] && !isDebug; // see [RL1] see [RL23]
    hitFlashDirect = 1'b0;
    for (int i = 0; i < N_BANK; i++) begin
      if (inRange(nsAddr, B_CSRAM + SZ_512K * i, SZ_512K)) begin
        hit[TGT_CSRAM0 + i] = 1'b1; // see [RL6]
      end
      // last bank end address misprinted; 32KB limit used
      if (inRange(nsAddr, B_ISRAM + SZ_32K * i, SZ_32K)) begin
        hit[TGT_ISRAM0 + i] = 1'b1; // see [RL9]
      end
      if (secView && inRange(addr, B_PROT + SZ_4K * i, SZ_4K)) begin
        hit[TGT_PROT0 + i] = 1'b1; // see [RL17]
      end
    end
    for (int i = 0; i < N_SER; i++) begin
      if (inRange(nsAddr, B_SER + SZ_4K * i, SZ_4K)) begin
        hit[TGT_SER0 + i] = 1'b1; // see [RL18]
      end
    end
    if (inRange(nsAddr, B_BOOTFL, SZ_8M)) begin
      hit[TGT_BOOTFL] = 1'b1; // see [RL7]
      hitFlashDirect = inRange(nsAddr, B_BOOTFL, SZ_256K);
    end
    // 256-byte range kept; printed 1KB size ignored
    hit[TGT_OTP] = inRange(nsAddr, B_OTP, SZ_OTP); // see [RL8]
    hit[TGT_TIM0] = inRange(nsAddr, B_TIM0, SZ_4K); // see [RL10]
    hit[TGT_TIM1] = inRange(nsAddr, B_TIM1, SZ_4K); // see [RL10]
    hit[TGT_DTIM] = inRange(nsAddr, B_DTIM, SZ_4K); // see [RL10]
    hit[TGT_MSG0] = inRange(nsAddr, B_MSG0, SZ_4K); // see [RL11]
    hit[TGT_MSG1] = inRange(nsAddr, B_MSG1, SZ_4K); // see [RL11]
    hit[TGT_PRIV] = inRange(nsAddr, B_PRIV, SZ_64K); // see [RL12]
    hit[TGT_SYSINFO] = inRange(nsAddr, B_SYSINFO, SZ_4K); // see [RL13]
    hit[TGT_SYSCTL] = inRange(addr, B_SYSCTL, SZ_4K); // see [RL13]
    hit[TGT_SWDOG] = inRange(addr, B_SWDOG, SZ_4K); // see [RL14]
    hit[TGT_XTIM] = inRange(nsAddr, B_XTIM, SZ_4K); // see [RL14]
    hit[TGT_NSPRIV] = inRange(addr, B_NSPRIV, SZ_4K); // see [RL15]
    hit[TGT_SPRIV] = inRange(addr, B_SPRIV, SZ_4K); // see [RL15]
    hit[TGT_WDOG] = inRange(nsAddr, B_WDOG, SZ_4K); // see [RL16]
    hit[TGT_PWM0] = inRange(nsAddr, B_PWM0, SZ_4K); // see [RL19]
    hit[TGT_RTC] = inRange(nsAddr, B_RTC, SZ_4K); // see [RL19]
    hit[TGT_FLCTL] = inRange(nsAddr, B_FLCTL, SZ_4K); // see [RL19]
    hit[TGT_GPTIM] = inRange(nsAddr, B_GPTIM, SZ_4K); // see [RL19]
    hit[TGT_SCFG] = inRange(nsAddr, B_SCFG, SZ_4K); // see [RL19]
    hit[TGT_PWM1] = inRange(nsAddr, B_PWM1, SZ_4K); // see [RL20]
    hit[TGT_PWM2] = inRange(nsAddr, B_PWM2, SZ_4K); // see [RL20]
    hit[TGT_GPIO] = inRange(nsAddr, B_GPIO, SZ_4K); // see [RL20]
    hit[TGT_FLPROT] = inRange(nsAddr, B_FLPROT, SZ_4K); // see [RL20]
    hit[TGT_CSPROT] = inRange(nsAddr, B_CSPROT, SZ_4K); // see [RL20]
    hit[TGT_EXP0] = inRange(addr, B_EXP0, WIN_SIZE); // see [RL21]
    // everything else, including 0x6xxx_xxxx, falls to default
    hit[TGT_DFLT] = (hit == '0); // see [RL21] see [RL22]
    hitSecure = secView;
  end

  // ==========================================================
  // registered outputs
  // ==========================================================
  logic next_selValid;
  logic [TGT_W-1:0] next_sel;
  logic next_selSecure;
  logic next_flashDirect;
  logic [ADDR_W-1:0] next_selAddr;

  always_comb begin
    next_selValid = selValid;
    next_sel = sel;
    next_selSecure = selSecure;
    next_flashDirect = flashDirect;
    next_selAddr = selAddr;
    if (clkEn) begin
      next_selValid = addrValid;
      // selects drop between accesses so no stale target stays chosen
      next_sel = addrValid ? hit : '0; // see [RL22]
      next_selSecure = addrValid && hitSecure; // see [RL23]
      next_flashDirect = addrValid && hitFlashDirect; // see [RL7]
      next_selAddr = addrValid ? addr : '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      selValid <= 1'b0; // see [RL5]
      sel <= '0;
      selSecure <= 1'b0;
      flashDirect <= 1'b0;
      selAddr <= '0;
    end else begin
      selValid <= next_selValid;
      sel <= next_sel;
      selSecure <= next_selSecure;
      flashDirect <= next_flashDirect;
      selAddr <= next_selAddr;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  property p_onehot;
    @(posedge ref_clk) disable iff (!rst_n)
      selValid |-> $onehot(sel);
  endproperty
  a_onehot: assert property (p_onehot) // see [RL22]
    else $error("selects not one-hot");

  property p_idle;
    @(posedge ref_clk) disable iff (!rst_n)
      !selValid |-> (sel == '0);
  endproperty
  a_idle: assert property (p_idle) // see [RL22]
    else $error("select without valid");

  property p_secbit;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && addr < DBG_BASE) |=>
        (selSecure == selAddr[SEC_BIT]);
  endproperty
  a_secbit: assert property (p_secbit) // see [RL23]
    else $error("secure attribute not from bit 28");

  property p_csram;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && inRange(addr, B_CSRAM + WIN_SIZE,
        SZ_512K * N_BANK)) |=>
        sel[TGT_CSRAM0 + int'((foldNs(selAddr) - B_CSRAM) / SZ_512K)];
  endproperty
  a_csram: assert property (p_csram) // see [RL6]
    else $error("secure code sram bank missed");

  property p_flash;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid) |=>
        (flashDirect |-> sel[TGT_BOOTFL]);
  endproperty
  a_flash: assert property (p_flash) // see [RL7]
    else $error("direct flash outside window");

  property p_sysctlns;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && inRange(addr, B_SYSCTL - WIN_SIZE, SZ_4K)) |=>
        (!sel[TGT_SYSCTL] && sel[TGT_DFLT]);
  endproperty
  a_sysctlns: assert property (p_sysctlns) // see [RL13]
    else $error("non-secure system control hit");

  property p_protsec;
    @(posedge ref_clk) disable iff (!rst_n)
      (|sel[TGT_PROT3:TGT_PROT0]) |-> (selSecure && selValid);
  endproperty
  a_protsec: assert property (p_protsec) // see [RL17]
    else $error("protection controller in non-secure view");

  property p_nsdflt;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && inRange(addr, B_DFLTNS, WIN_SIZE)) |=>
        sel[TGT_DFLT];
  endproperty
  a_nsdflt: assert property (p_nsdflt) // see [RL21]
    else $error("0x6 window not default");

  property p_exp;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && inRange(addr, B_EXP0, WIN_SIZE)) |=>
        sel[TGT_EXP0];
  endproperty
  a_exp: assert property (p_exp) // see [RL21]
    else $error("0x7 window not expansion");

  property p_reset;
    @(posedge ref_clk) !rst_n |=> (!selValid && sel == '0);
  endproperty
  a_reset: assert property (p_reset) // see [RL5]
    else $error("state not cleared by reset");

  property p_debug;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && addr >= DBG_BASE) |=>
        (sel[TGT_DFLT] && !selSecure);
  endproperty
  a_debug: assert property (p_debug) // see [RL2]
    else $error("debug area decoded by security view");

  property p_flashlim;
    @(posedge ref_clk) disable iff (!rst_n)
      flashDirect |->
        ((foldNs(selAddr) - B_BOOTFL) < SZ_256K);
  endproperty
  a_flashlim: assert property (p_flashlim) // see [RL7]
    else $error("direct flash beyond reachable part");

  property p_otpend;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && inRange(foldNs(addr), B_OTP + SZ_OTP, SZ_OTP))
        |=> sel[TGT_DFLT];
  endproperty
  a_otpend: assert property (p_otpend) // see [RL8]
    else $error("otp block wider than 256 bytes");

  property p_isram3;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && inRange(foldNs(addr),
        B_ISRAM + SZ_32K * (N_BANK - 1), SZ_32K)) |=> sel[TGT_ISRAM3];
  endproperty
  a_isram3: assert property (p_isram3) // see [RL9]
    else $error("last internal sram bank missed");

  property p_timsec;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && inRange(addr, B_TIM0 + WIN_SIZE, SZ_4K)) |=>
        (sel[TGT_TIM0] && selSecure);
  endproperty
  a_timsec: assert property (p_timsec) // see [RL10]
    else $error("secure timer alias missed");

  property p_priv;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && inRange(foldNs(addr), B_PRIV, SZ_64K)) |=>
        sel[TGT_PRIV];
  endproperty
  a_priv: assert property (p_priv) // see [RL12]
    else $error("private core region missed");

  property p_swdogns;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && inRange(addr, B_SWDOG - WIN_SIZE, SZ_4K)) |=>
        sel[TGT_DFLT];
  endproperty
  a_swdogns: assert property (p_swdogns) // see [RL14]
    else $error("secure watchdog seen in non-secure view");

  property p_privctl;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && inRange(addr, B_NSPRIV, SZ_4K)) |=>
        (sel[TGT_NSPRIV] && !selSecure);
  endproperty
  a_privctl: assert property (p_privctl) // see [RL15]
    else $error("non-secure privilege control missed");

  property p_wdog;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && inRange(foldNs(addr), B_WDOG, SZ_4K)) |=>
        sel[TGT_WDOG];
  endproperty
  a_wdog: assert property (p_wdog) // see [RL16]
    else $error("watchdog region missed");

  property p_ser5;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && inRange(foldNs(addr),
        B_SER + SZ_4K * (N_SER - 1), SZ_4K)) |=> sel[TGT_SER5];
  endproperty
  a_ser5: assert property (p_ser5) // see [RL18]
    else $error("last serial slot missed");

  property p_scfg;
    @(posedge ref_clk) disable iff (!rst_n)
      (clkEn && addrValid && inRange(foldNs(addr), B_SCFG, SZ_4K)) |=>
        sel[TGT_SCFG];
  endproperty
  a_scfg: assert property (p_scfg) // see [RL19]
    else $error("serial configuration region missed");

  c_uart: cover property (@(posedge ref_clk) sel[TGT_SER0] && selSecure);
  c_dflt: cover property (@(posedge ref_clk) sel[TGT_DFLT]);
  c_flash: cover property (@(posedge ref_clk) flashDirect);
  c_prot: cover property (@(posedge ref_clk) sel[TGT_PROT3]);

endmodule // sad_decoder

// >>> inc/sad_pkg.sv
/*
  Address map constants and target enumeration for the system address
  decoder. Assumes a 32-bit byte address from one upstream bus master.
*/
package sad_pkg;

  localparam int ADDR_W = 32;

  // target indices; selects form a one-hot vector of this width
  typedef enum int {
    TGT_CSRAM0 = 0, TGT_CSRAM1 = 1, TGT_CSRAM2 = 2, TGT_CSRAM3 = 3,
    TGT_BOOTFL = 4, TGT_OTP = 5,
    TGT_ISRAM0 = 6, TGT_ISRAM1 = 7, TGT_ISRAM2 = 8, TGT_ISRAM3 = 9,
    TGT_TIM0 = 10, TGT_TIM1 = 11, TGT_DTIM = 12,
    TGT_MSG0 = 13, TGT_MSG1 = 14, TGT_PRIV = 15,
    TGT_SYSINFO = 16, TGT_SYSCTL = 17, TGT_SWDOG = 18, TGT_XTIM = 19,
    TGT_NSPRIV = 20, TGT_SPRIV = 21, TGT_WDOG = 22,
    TGT_PROT0 = 23, TGT_PROT1 = 24, TGT_PROT2 = 25, TGT_PROT3 = 26,
    TGT_SER0 = 27, TGT_SER1 = 28, TGT_SER2 = 29, TGT_SER3 = 30,
    TGT_SER4 = 31, TGT_SER5 = 32,
    TGT_PWM0 = 33, TGT_RTC = 34, TGT_FLCTL = 35, TGT_GPTIM = 36,
    TGT_SCFG = 37, TGT_PWM1 = 38, TGT_PWM2 = 39, TGT_GPIO = 40,
    TGT_FLPROT = 41, TGT_CSPROT = 42,
    TGT_EXP0 = 43, TGT_DFLT = 44
  } sad_tgt_t;

  localparam int NUM_TGT = 45;

  // sram bank count per array and serial slot count
  localparam int N_BANK = 4;
  localparam int N_SER = 6;

  // security window bit and alternation size (256MB)
  localparam int SEC_BIT = 28;
  localparam logic [31:0] WIN_SIZE = 32'h1000_0000;
  // debug-related addresses exempt from alternation: system region top
  localparam logic [31:0] DBG_BASE = 32'he000_0000;

  // region sizes
  localparam logic [31:0] SZ_4K = 32'h0000_1000;
  localparam logic [31:0] SZ_32K = 32'h0000_8000;
  localparam logic [31:0] SZ_64K = 32'h0001_0000;
  localparam logic [31:0] SZ_256K = 32'h0004_0000;
  localparam logic [31:0] SZ_512K = 32'h0008_0000;
  localparam logic [31:0] SZ_8M = 32'h0080_0000;
  localparam logic [31:0] SZ_OTP = 32'h0000_0100;

  // non-secure bases, or the secure address for secure-only blocks; secure alias = base + WIN_SIZE where both views exist
  localparam logic [31:0] B_CSRAM = 32'h0000_0000;
  localparam logic [31:0] B_BOOTFL = 32'h0020_0000;
  localparam logic [31:0] B_OTP = 32'h0e00_0000;
  localparam logic [31:0] B_ISRAM = 32'h2000_0000;
  localparam logic [31:0] B_TIM0 = 32'h4000_0000;
  localparam logic [31:0] B_TIM1 = 32'h4000_1000;
  localparam logic [31:0] B_DTIM = 32'h4000_2000;
  localparam logic [31:0] B_MSG0 = 32'h4000_3000;
  localparam logic [31:0] B_MSG1 = 32'h4000_4000;
  localparam logic [31:0] B_PRIV = 32'h4001_0000;
  localparam logic [31:0] B_SYSINFO = 32'h4002_0000;
  localparam logic [31:0] B_SYSCTL = 32'h5002_1000;
  localparam logic [31:0] B_SWDOG = 32'h5002_e000;
  localparam logic [31:0] B_XTIM = 32'h4002_f000;
  localparam logic [31:0] B_NSPRIV = 32'h4008_0000;
  localparam logic [31:0] B_SPRIV = 32'h5008_0000;
  localparam logic [31:0] B_WDOG = 32'h4008_1000;
  localparam logic [31:0] B_PROT = 32'h5008_3000;
  localparam logic [31:0] B_SER = 32'h4010_1000;
  localparam logic [31:0] B_PWM0 = 32'h4010_7000;
  localparam logic [31:0] B_RTC = 32'h4010_8000;
  localparam logic [31:0] B_FLCTL = 32'h4010_a000;
  localparam logic [31:0] B_GPTIM = 32'h4010_b000;
  localparam logic [31:0] B_SCFG = 32'h4010_c000;
  localparam logic [31:0] B_PWM1 = 32'h4010_e000;
  localparam logic [31:0] B_PWM2 = 32'h4010_f000;
  localparam logic [31:0] B_GPIO = 32'h4011_0000;
  localparam logic [31:0] B_FLPROT = 32'h4012_0000;
  localparam logic [31:0] B_CSPROT = 32'h4013_0000;
  localparam logic [31:0] B_EXP0 = 32'h7000_0000;
  localparam logic [31:0] B_DFLTNS = 32'h6000_0000;

endpackage

// >>> sim/sad_slave_model.sv
/*
  Downstream slave side model: turns each registered select into an
  okay or error response one cycle later.
  Assumes one-hot selects from the decoder on ref_clk.
*/
`timescale 1ns/1ps

module sad_slave_model
  import sad_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic selValid,
  input wire logic [NUM_TGT-1:0] sel,
  output logic respValid,
  output logic respErr
);

  // ==========================================================
  // response
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      respValid <= 1'b0;
      respErr <= 1'b0;
    end else begin
      respValid <= selValid;
      // reserved space gives no defined data, so answer with an error
      respErr <= selValid && sel[TGT_DFLT];
    end
  end

endmodule // sad_slave_model

// >>> sim/tb.sv
/*
  Self-checking bench for the system address decoder.
  Assumes the decode latency of one enabled edge and all-zero idle outputs.
*/
`timescale 1ns/1ps

module tb
  import sad_pkg::*;
;
  typedef struct {logic [31:0] a; int t; logic fl;} sad_exp_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b0;
  logic addrValid = 1'b0;
  logic [31:0] addr = 32'h0;
  logic enQ = 1'b0;
  logic lastDflt = 1'b0;
  wire logic selValid, selSecure, flashDirect, respValid, respErr;
  wire logic [NUM_TGT-1:0] sel;
  wire logic [31:0] selAddr;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  integer seed = 32'hda5dc3b0;
  sad_exp_t q[$];
  logic [31:0] pb [10] = '{B_PWM0, B_RTC, B_FLCTL, B_GPTIM, B_SCFG,
    B_PWM1, B_PWM2, B_GPIO, B_FLPROT, B_CSPROT};
  logic [31:0] un [9] = '{32'h4002_1000, 32'h4002_e000, 32'h4008_3000,
    32'h0e00_0100, 32'h2002_0000, 32'h00a0_0000, 32'h4010_9000,
    32'he000_0000, 32'hf000_0000};

  always #2 ref_clk = ~ref_clk;

  sad_decoder u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
    .addrValid(addrValid), .addr(addr), .selValid(selValid), .sel(sel),
    .selSecure(selSecure), .flashDirect(flashDirect), .selAddr(selAddr));

  sad_slave_model u_slv (.ref_clk(ref_clk), .rst_n(rst_n),
    .selValid(selValid), .sel(sel), .respValid(respValid),
    .respErr(respErr));

  // ==========================================================
  // helpers
  task automatic fail(input string m);
    n_fail++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic finish_test();
    $display("n_checks=%0d n_fail=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic send(input logic [31:0] a, input int t);
    sad_exp_t e;
    e.a = a;
    e.t = t;
    e.fl = (t == TGT_BOOTFL) && (((a & ~WIN_SIZE) - B_BOOTFL) < SZ_256K);
    @(negedge ref_clk);
    clkEn = 1'b1;
    addrValid = 1'b1;
    addr = a;
    q.push_back(e);
  endtask

  // both ends and one random offset, plus both ends of the secure alias if dual
  task automatic region(input logic [31:0] b, input logic [31:0] sz,
                        input int t, input bit dual);
    logic [31:0] off;
    off = $random(seed) & (sz - 32'h1);
    send(b, t);
    send(b + sz - 32'h1, t);
    send(b + off, t);
    if (dual) begin
      send(b + WIN_SIZE, t);
      send(b + WIN_SIZE + sz - 32'h1, t);
    end
  endtask

  // released address line carries junk so stale values cannot pass
  task automatic idle();
    @(negedge ref_clk);
    addrValid = 1'b0;
    addr = $random(seed);
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic rst_chk();
    n_checks++;
    if (selValid !== 1'b0 || sel !== '0 || selAddr !== 32'h0 ||
        selSecure !== 1'b0 || flashDirect !== 1'b0) fail("reset values");
  endtask

  // ==========================================================
  // monitor
  always @(posedge ref_clk) enQ <= clkEn && rst_n;

  always @(negedge ref_clk) begin : mon
    sad_exp_t e;
    logic [NUM_TGT-1:0] x;
    logic s;
    if (respValid === 1'b1) begin
      n_checks++;
      if (respErr !== lastDflt) fail("slave response");
    end
    if (selValid === 1'b1 && enQ) begin
      if (q.size() == 0) fail("unexpected select");
      else begin
        e = q.pop_front();
        x = '0;
        x[e.t] = 1'b1;
        s = e.a[SEC_BIT] && (e.a < DBG_BASE);
        lastDflt = (e.t == TGT_DFLT);
        n_checks++;
        if (sel !== x || selAddr !== e.a || flashDirect !== e.fl ||
            selSecure !== s) begin
          fail($sformatf("select for %h", e.a));
        end
      end
    end else if (enQ) begin
      // an unknown valid lands here too and fails
      n_checks++;
      if (selValid !== 1'b0 || sel !== '0 || selAddr !== 32'h0 ||
          selSecure !== 1'b0 || flashDirect !== 1'b0) begin
        fail("idle outputs");
      end
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail("timeout");
      finish_test();
    end
  end

  // ==========================================================
  // sequence
  initial begin
    repeat (4) @(negedge ref_clk);
    rst_chk();
    rst_n = 1'b1;
    for (int i = 0; i < N_BANK; i++)
      region(B_CSRAM + i * SZ_512K, SZ_512K, TGT_CSRAM0 + i, 1);
    region(B_BOOTFL, SZ_8M, TGT_BOOTFL, 1);
    send(B_BOOTFL + SZ_256K - 32'h1, TGT_BOOTFL);
    send(B_BOOTFL + SZ_256K, TGT_BOOTFL);
    region(B_OTP, SZ_OTP, TGT_OTP, 1);
    for (int i = 0; i < N_BANK; i++)
      region(B_ISRAM + i * SZ_32K, SZ_32K, TGT_ISRAM0 + i, 1);
    for (int i = 0; i < 5; i++)
      region(B_TIM0 + i * SZ_4K, SZ_4K, TGT_TIM0 + i, 1);
    region(B_PRIV, SZ_64K, TGT_PRIV, 1);
    region(B_SYSINFO, SZ_4K, TGT_SYSINFO, 1);
    region(B_SYSCTL, SZ_4K, TGT_SYSCTL, 0);
    region(B_SWDOG, SZ_4K, TGT_SWDOG, 0);
    region(B_XTIM, SZ_4K, TGT_XTIM, 1);
    region(B_NSPRIV, SZ_4K, TGT_NSPRIV, 0);
    region(B_SPRIV, SZ_4K, TGT_SPRIV, 0);
    region(B_WDOG, SZ_4K, TGT_WDOG, 1);
    for (int i = 0; i < N_BANK; i++)
      region(B_PROT + i * SZ_4K, SZ_4K, TGT_PROT0 + i, 0);
    for (int i = 0; i < N_SER; i++)
      region(B_SER + i * SZ_4K, SZ_4K, TGT_SER0 + i, 1);
    for (int i = 0; i < 10; i++)
      region(pb[i], SZ_4K, TGT_PWM0 + i, 1);
    region(B_DFLTNS, WIN_SIZE, TGT_DFLT, 0);
    region(B_EXP0, WIN_SIZE, TGT_EXP0, 0);
    for (int i = 0; i < 9; i++) send(un[i], TGT_DFLT);
    idle();
    // frozen clock enable must hold the last answer and take nothing
    send(B_GPIO, TGT_GPIO);
    @(negedge ref_clk);
    clkEn = 1'b0;
    addr = B_TIM0;
    repeat (2) begin
      @(negedge ref_clk);
      n_checks++;
      if (selValid !== 1'b1 || sel[TGT_GPIO] !== 1'b1 ||
          selAddr !== B_GPIO) fail("hold");
    end
    @(negedge ref_clk);
    clkEn = 1'b1;
    addrValid = 1'b0;
    repeat (2) @(negedge ref_clk);
    // reset in mid-traffic clears everything
    send(B_TIM1, TGT_TIM1);
    @(negedge ref_clk);
    rst_n = 1'b0;
    addr = B_GPIO;
    @(negedge ref_clk);
    rst_chk();
    rst_n = 1'b1;
    addrValid = 1'b0;
    idle();
    // decoding must resume after the mid-run reset
    send(B_TIM0 + WIN_SIZE, TGT_TIM0);
    idle();
    n_checks++;
    if (q.size() != 0) fail("missing selects");
    finish_test();
  end

endmodule // tb
